//--- design/opps_sequencer.sv
`timescale 1ns/100ps
// How it works
// - The voltage setpoint is held as 11 bits and the current limit as 7 bits.
// - Reverse output is allowed only with battery above its rising threshold, no overvoltage, bus under UVLO, thermistor in range.
// - With no switch pair detected, the converter starts 5 ms after the enable bit is set, then ramps to the setpoint.
// - With one pair detected, start waits until the host sets that pair's driver enable bit.
// - With both pairs detected, start waits until the host sets either driver enable bit.
// - Once a driver enable releases a pending start, the converter starts 5 ms later and ramps.
// - With global driver disable set, drivers are off, detection ignored, start follows enable by 5 ms.
// - Clearing the active driver bit stops switching; with both pairs detected, setting the other bit restarts and turns that driver on.
// - In reverse mode pulse-frequency operation and the audio floor are disabled by their own bits.
// - Discharge over its 2-bit limit reduces output current and sets status; unmasked it sets the flag and pulses interrupt.
// - The minimum-system status is high while the rail is held at minimum system voltage.
// - Input voltage and current regulation status follow their active loops.
// - With battery below the minimum setting the battery switch runs linear, rail 200 mV above minimum.
// - With charging off above minimum, or terminated, the rail target is 200 mV or 600 mV with pulse-frequency on.
// - Supplement mode turns the battery switch on when the rail falls below battery, off at depletion.
// - A fully charged battery turns the battery switch off unless supplement mode holds it on.
module opps_sequencer
    import opps_pkg::*;
#(
    parameter int unsigned START_CYC = START_DELAY_CYC
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // Host control bits
    input  wire logic                  reverse_output_enable,
    input  wire logic [VSET_W-1:0]     reverse_voltage_setpoint,
    input  wire logic [ILIM_W-1:0]     reverse_current_limit,
    input  wire logic                  input_driver1_enable,
    input  wire logic                  input_driver2_enable,
    input  wire logic                  input_driver_global_disable,
    input  wire logic                  reverse_pulse_freq_disable,
    input  wire logic                  reverse_audio_floor_disable,
    input  wire logic [DLIM_W-1:0]     discharge_limit_setting,
    input  wire logic                  discharge_limit_mask,
    input  wire logic                  discharge_limit_flag_clear,
    input  wire logic                  charge_enable,
    // Power-on detection of input switch pairs
    input  wire logic                  input_pair1_detected,
    input  wire logic                  input_pair2_detected,
    // Analog comparator results (asynchronous)
    input  wire logic                  battery_above_otg_rise,
    input  wire logic                  battery_overvoltage,
    input  wire logic                  bus_below_uvlo,
    input  wire logic [THERM_W-1:0]    thermistor_input,
    input  wire logic [THERM_W-1:0]    thermistor_hot_limit,
    input  wire logic [THERM_W-1:0]    thermistor_cold_limit,
    input  wire logic [DLIM_W-1:0]     discharge_level,
    input  wire logic                  system_at_min,
    input  wire logic                  input_voltage_limit_loop,
    input  wire logic                  input_current_limit_loop,
    input  wire logic                  battery_below_min_system,
    input  wire logic                  system_below_battery,
    input  wire logic                  battery_depleted,
    input  wire logic                  charge_terminated,
    // Converter control
    output logic                       converter_switching,
    output logic                       bus_ramp_active,
    output logic [VSET_W-1:0]          ramp_voltage_target,
    output logic [ILIM_W-1:0]          output_current_limit,
    output logic                       output_current_reduce,
    output logic                       input_switch_driver1,
    output logic                       input_switch_driver2,
    output logic                       pulse_frequency_mode_en,
    output logic                       audio_frequency_floor_en,
    // Status to host
    output logic                       discharge_limit_status,
    output logic                       discharge_limit_flag,
    output logic                       interrupt_pulse,
    output logic                       min_system_reg_status,
    output logic                       input_voltage_reg_status,
    output logic                       input_current_reg_status,
    output logic [1:0]                 battery_switch_mode,
    output logic [9:0]                 system_headroom_mv
);
    // Two-stage synchronisers for the analog comparator inputs
    localparam int unsigned SW = 12 + THERM_W + DLIM_W;

    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {battery_above_otg_rise, battery_overvoltage, bus_below_uvlo,
                          system_at_min, input_voltage_limit_loop, input_current_limit_loop,
                          battery_below_min_system, system_below_battery, battery_depleted,
                          charge_terminated, input_pair1_detected, input_pair2_detected,
                          thermistor_input, discharge_level};
            sync2_reg <= sync1_reg;
        end
    end

    logic               s_bat_ok;
    logic               s_bat_ovp;
    logic               s_bus_low;
    logic               s_sys_min;
    logic               s_vloop;
    logic               s_iloop;
    logic               s_bat_low;
    logic               s_sys_below;
    logic               s_depleted;
    logic               s_term;
    logic               s_pair1;
    logic               s_pair2;
    logic [THERM_W-1:0] s_therm;
    logic [DLIM_W-1:0]  s_dis;

    assign {s_bat_ok, s_bat_ovp, s_bus_low, s_sys_min, s_vloop, s_iloop, s_bat_low,
            s_sys_below, s_depleted, s_term, s_pair1, s_pair2, s_therm, s_dis} = sync2_reg;

    // Pair detection is latched once after reset release, as a power-on strap
    logic [1:0] fill_reg;
    logic       sync2_valid_reg;
    logic pair1_reg;
    logic pair2_reg;
    logic strap_done_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pair1_reg      <= 1'b0;
            pair2_reg      <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg && sync2_valid_reg) begin
            pair1_reg      <= s_pair1;
            pair2_reg      <= s_pair2;
            strap_done_reg <= 1'b1;
        end
    end

    // Wait for the synchroniser to fill before latching the strap

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fill_reg        <= 2'h0;
            sync2_valid_reg <= 1'b0;
        end else if (fill_reg != 2'h3) begin
            fill_reg        <= fill_reg + 2'h1;
        end else begin
            sync2_valid_reg <= 1'b1;
        end
    end

    // Thermistor window: hot limit is the low reading, cold the high one
    function automatic logic in_window(input logic [THERM_W-1:0] v,
                                       input logic [THERM_W-1:0] lo,
                                       input logic [THERM_W-1:0] hi);
        in_window = (v >= lo) && (v <= hi);
    endfunction

    logic allowed;
    assign allowed = strap_done_reg && s_bat_ok && !s_bat_ovp && s_bus_low
                     && in_window(s_therm, thermistor_hot_limit, thermistor_cold_limit);

    // Driver gating depending on which pairs were present
    logic drv_release;
    logic need_driver;

    always_comb begin
        need_driver = !input_driver_global_disable && (pair1_reg || pair2_reg);
        if (!need_driver) begin
            drv_release = 1'b1;
        end else if (pair1_reg && pair2_reg) begin
            drv_release = input_driver1_enable || input_driver2_enable;
        end else if (pair1_reg) begin
            drv_release = input_driver1_enable;
        end else begin
            drv_release = input_driver2_enable;
        end
    end

    logic go;
    assign go = reverse_output_enable && allowed && drv_release;

    // Sequencer
    opps_state_t state_reg;
    opps_state_t state_next;
    logic        delay_done;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OPPS_IDLE: begin
                if (reverse_output_enable && allowed) begin
                    state_next = drv_release ? OPPS_DELAY : OPPS_WAIT_DRV;
                end
            end
            OPPS_WAIT_DRV: begin
                if (!reverse_output_enable || !allowed) begin
                    state_next = OPPS_IDLE;
                end else if (drv_release) begin
                    state_next = OPPS_DELAY;
                end
            end
            OPPS_DELAY: begin
                if (!reverse_output_enable || !allowed) begin
                    state_next = OPPS_IDLE;
                end else if (!drv_release) begin
                    state_next = OPPS_WAIT_DRV;
                end else if (delay_done) begin
                    state_next = OPPS_RAMP;
                end
            end
            OPPS_RAMP: begin
                // Driver bit dropped mid-operation stops switching and lets the bus fall
                if (!go) begin
                    state_next = (reverse_output_enable && allowed) ? OPPS_WAIT_DRV : OPPS_IDLE;
                end
            end
            default: state_next = OPPS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= OPPS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    opps_delay_timer #(
        .COUNT (START_CYC)
    ) u_start_delay (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (state_reg == OPPS_DELAY && state_next == OPPS_DELAY),
        .done    (delay_done)
    );

    // Converter outputs; setpoints copied every cycle in any state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            converter_switching  <= 1'b0;
            bus_ramp_active      <= 1'b0;
            ramp_voltage_target  <= VSET_RST;
            output_current_limit <= ILIM_RST;
            input_switch_driver1 <= 1'b0;
            input_switch_driver2 <= 1'b0;
        end else begin
            converter_switching  <= (state_next == OPPS_RAMP);
            bus_ramp_active      <= (state_next == OPPS_RAMP);
            ramp_voltage_target  <= reverse_voltage_setpoint;
            output_current_limit <= reverse_current_limit;
            // Drivers follow host bits only when the pair exists and drivers are not disabled
            input_switch_driver1 <= (state_next == OPPS_RAMP) && !input_driver_global_disable
                                    && pair1_reg && input_driver1_enable;
            input_switch_driver2 <= (state_next == OPPS_RAMP) && !input_driver_global_disable
                                    && pair2_reg && input_driver2_enable;
        end
    end

    // Light-load modes in reverse operation
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_frequency_mode_en  <= 1'b0;
            audio_frequency_floor_en <= 1'b0;
        end else begin
            pulse_frequency_mode_en  <= (state_next == OPPS_RAMP) && !reverse_pulse_freq_disable;
            audio_frequency_floor_en <= (state_next == OPPS_RAMP) && !reverse_audio_floor_disable;
        end
    end

    // Discharge limit; flag set wins over a same-cycle clear
    logic over_limit;
    logic over_prev_reg;

    assign over_limit = (state_reg == OPPS_RAMP) && (s_dis > discharge_limit_setting);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            discharge_limit_status <= 1'b0;
            output_current_reduce  <= 1'b0;
            discharge_limit_flag   <= 1'b0;
            interrupt_pulse        <= 1'b0;
            over_prev_reg          <= 1'b0;
        end else begin
            over_prev_reg          <= over_limit;
            discharge_limit_status <= over_limit;
            output_current_reduce  <= over_limit;
            interrupt_pulse        <= over_limit && !over_prev_reg && !discharge_limit_mask;
            if (over_limit && !over_prev_reg && !discharge_limit_mask) begin
                discharge_limit_flag <= 1'b1;
            end else if (discharge_limit_flag_clear) begin
                discharge_limit_flag <= 1'b0;
            end
        end
    end

    // Power-path status
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            min_system_reg_status    <= 1'b0;
            input_voltage_reg_status <= 1'b0;
            input_current_reg_status <= 1'b0;
        end else begin
            min_system_reg_status    <= s_sys_min;
            input_voltage_reg_status <= s_vloop;
            input_current_reg_status <= s_iloop;
        end
    end

    // Battery switch and system headroom
    logic supplement_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            supplement_reg <= 1'b0;
        end else if (s_depleted) begin
            supplement_reg <= 1'b0;
        end else if (s_sys_below) begin
            supplement_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            battery_switch_mode <= OPPS_BSW_OFF;
            system_headroom_mv  <= LDO_HEADROOM_MV;
        end else begin
            // Supplement takes priority so the rail never collapses on a full battery
            if (supplement_reg) begin
                battery_switch_mode <= OPPS_BSW_ON;
            end else if (s_bat_low) begin
                battery_switch_mode <= OPPS_BSW_LINEAR;
            end else if (s_term) begin
                battery_switch_mode <= OPPS_BSW_OFF;
            end else begin
                battery_switch_mode <= charge_enable ? OPPS_BSW_ON : OPPS_BSW_OFF;
            end
            if (s_bat_low) begin
                system_headroom_mv <= LDO_HEADROOM_MV;
            end else if (!charge_enable || s_term) begin
                system_headroom_mv <= pulse_frequency_mode_en ? HEADROOM_PFM_ON_MV
                                                              : HEADROOM_PFM_OFF_MV;
            end else begin
                system_headroom_mv <= 10'h000;
            end
        end
    end
endmodule

//--- shared/opps_pkg.sv
package opps_pkg;
    // Clock and start-up timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned START_DELAY_US  = 5_000;
    localparam int unsigned START_DELAY_CYC = (CLK_HZ / 1_000_000) * START_DELAY_US;

    // Field widths
    localparam int unsigned VSET_W   = 11;
    localparam int unsigned ILIM_W   = 7;
    localparam int unsigned DLIM_W   = 2;
    localparam int unsigned THERM_W  = 8;

    // System-above-battery targets in mV
    localparam logic [9:0] LDO_HEADROOM_MV = 10'd200;
    localparam logic [9:0] HEADROOM_PFM_OFF_MV = 10'd200;
    localparam logic [9:0] HEADROOM_PFM_ON_MV  = 10'd600;

    // Reset values
    localparam logic [VSET_W-1:0] VSET_RST = 11'h000;
    localparam logic [ILIM_W-1:0] ILIM_RST = 7'h00;

    typedef enum logic [2:0] {
        OPPS_IDLE,
        OPPS_WAIT_DRV,
        OPPS_DELAY,
        OPPS_RAMP
    } opps_state_t;

    // Battery switch modes
    typedef enum logic [1:0] {
        OPPS_BSW_OFF,
        OPPS_BSW_LINEAR,
        OPPS_BSW_ON
    } opps_bsw_t;
endpackage

//--- design/opps_delay_timer.sv
`timescale 1ns/100ps
// Restartable up-counter: done rises after count cycles of run and holds until run drops.
module opps_delay_timer #(
    parameter int unsigned COUNT = 250_000
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Control
    input  wire logic run,
    output logic      done
);
    localparam int unsigned CW = $clog2(COUNT + 1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !run) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else if (cnt_reg == CW'(COUNT - 1)) begin
            done    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
            done    <= 1'b0;
        end
    end
endmodule

//--- tb/opps_sequencer_properties.sv
`timescale 1ns/100ps
module opps_checker
    import opps_pkg::*;
#(
    parameter int unsigned START_CYC = 20
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // Host bits
    input wire logic              reverse_output_enable,
    input wire logic [VSET_W-1:0] reverse_voltage_setpoint,
    input wire logic [ILIM_W-1:0] reverse_current_limit,
    input wire logic              input_driver_global_disable,
    input wire logic              reverse_pulse_freq_disable,
    input wire logic              reverse_audio_floor_disable,
    input wire logic              system_at_min,
    // Outputs watched
    input wire logic              converter_switching,
    input wire logic              bus_ramp_active,
    input wire logic [VSET_W-1:0] ramp_voltage_target,
    input wire logic [ILIM_W-1:0] output_current_limit,
    input wire logic              output_current_reduce,
    input wire logic              input_switch_driver1,
    input wire logic              input_switch_driver2,
    input wire logic              pulse_frequency_mode_en,
    input wire logic              audio_frequency_floor_en,
    input wire logic              discharge_limit_status,
    input wire logic              interrupt_pulse,
    input wire logic              min_system_reg_status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    int unsigned en_cnt_reg;
    // Saturates so a long enable cannot wrap and fake an early start
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !reverse_output_enable) begin
            en_cnt_reg <= 0;
        end else if (en_cnt_reg < START_CYC + 8) begin
            en_cnt_reg <= en_cnt_reg + 1;
        end
    end
    sequence s_en_lost;
        converter_switching && !reverse_output_enable;
    endsequence
    sequence s_start;
        !converter_switching ##1 converter_switching;
    endsequence
    a_stop_on_loss: assert property (s_en_lost |=> !converter_switching)
        else $error("switching held after enable cleared");
    a_start_delay: assert property (s_start |-> en_cnt_reg >= START_CYC)
        else $error("converter started before delay");
    a_ramp_in_run: assert property (converter_switching |-> bus_ramp_active)
        else $error("ramp not active while switching");
    a_setpoint_copy: assert property ($past(rst_n) |-> ramp_voltage_target == $past(reverse_voltage_setpoint)
        && output_current_limit == $past(reverse_current_limit)) else $error("setpoint not copied");
    a_pfm_follow: assert property (converter_switching && $stable(reverse_pulse_freq_disable)
        |-> pulse_frequency_mode_en == !reverse_pulse_freq_disable) else $error("pfm enable wrong");
    a_floor_follow: assert property (converter_switching && $stable(reverse_audio_floor_disable)
        |-> audio_frequency_floor_en == !reverse_audio_floor_disable) else $error("audio floor wrong");
    a_drivers_off: assert property (input_driver_global_disable && $past(input_driver_global_disable)
        |-> !input_switch_driver1 && !input_switch_driver2) else $error("driver on while disabled");
    a_reduce_status: assert property (output_current_reduce == discharge_limit_status)
        else $error("reduce and status differ");
    a_irq_pulse: assert property (interrupt_pulse |-> discharge_limit_status ##1 !interrupt_pulse)
        else $error("interrupt pulse wrong");
    a_min_status: assert property (system_at_min [*5] |-> min_system_reg_status)
        else $error("min system status low");
endmodule
bind opps_sequencer opps_checker #(.START_CYC(START_CYC)) i_opps_checker (.*);

//--- tb/opps_host_model.sv
`timescale 1ns/100ps
module opps_host_model (
    // Clock
    input  wire logic clk_sys,
    // Host control bits
    output logic      reverse_output_enable,
    output logic      input_driver1_enable,
    output logic      input_driver2_enable,
    output logic      input_driver_global_disable
);
    initial begin
        reverse_output_enable = 1'b0;
        input_driver1_enable = 1'b0;
        input_driver2_enable = 1'b0;
        input_driver_global_disable = 1'b0;
    end
    // A swap is two writes: clear the active driver bit, then set the other
    task automatic write_ctrl(input logic en, input logic d1, input logic d2, input logic gd);
        @(posedge clk_sys);
        #1;
        reverse_output_enable = en;
        input_driver1_enable = d1;
        input_driver2_enable = d2;
        input_driver_global_disable = gd;
    endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import opps_pkg::*;
    localparam int SC = 20;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic reverse_output_enable, input_driver1_enable, input_driver2_enable, input_driver_global_disable;
    logic [10:0] reverse_voltage_setpoint = 11'h5a5;
    logic [6:0] reverse_current_limit = 7'h33;
    logic [1:0] discharge_limit_setting = 2'h1, discharge_level = 2'h0;
    logic [7:0] thermistor_input = 8'hc0, thermistor_hot_limit = 8'h20, thermistor_cold_limit = 8'hc0;
    logic reverse_pulse_freq_disable = 0, reverse_audio_floor_disable = 0, discharge_limit_mask = 0;
    logic discharge_limit_flag_clear = 0, charge_enable = 0, input_pair1_detected = 0, input_pair2_detected = 0;
    logic battery_above_otg_rise = 1, battery_overvoltage = 0, bus_below_uvlo = 1, system_at_min = 0;
    logic input_voltage_limit_loop = 0, input_current_limit_loop = 0, battery_below_min_system = 0;
    logic system_below_battery = 0, battery_depleted = 0, charge_terminated = 0;
    logic converter_switching, bus_ramp_active, output_current_reduce, input_switch_driver1;
    logic input_switch_driver2, pulse_frequency_mode_en, audio_frequency_floor_en, discharge_limit_status;
    logic discharge_limit_flag, interrupt_pulse, min_system_reg_status, input_voltage_reg_status;
    logic input_current_reg_status;
    logic [10:0] ramp_voltage_target;
    logic [6:0] output_current_limit;
    logic [1:0] battery_switch_mode;
    logic [9:0] system_headroom_mv;
    int mismatches = 0, checked = 0, irq_cnt = 0, n;

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (interrupt_pulse === 1'b1) irq_cnt++;

    opps_sequencer #(.START_CYC(SC)) i_opps_sequencer (.*);
    opps_host_model i_host (.*);

    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_sw(input int lim);
        n = 0;
        while (converter_switching !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
    endtask
    // Straps are latched once after reset, so each pair setup needs its own reset
    task automatic do_reset(input logic p1, input logic p2);
        i_host.write_ctrl(0, 0, 0, 0);
        input_pair1_detected = p1;
        input_pair2_detected = p2;
        rst_n = 1'b0;
        cyc(4);
        rst_n = 1'b1;
        cyc(8);
    endtask
    task automatic start_ok(input int d1, input int d2);
        wait_sw(SC + 40);
        chk("start_late", 1, n >= SC);
        chk("switching", 1, converter_switching);
        chk("driver1", d1, input_switch_driver1);
        chk("driver2", d2, input_switch_driver2);
    endtask
    task automatic stays_off(input string nm);
        cyc(SC + 30);
        chk(nm, 0, converter_switching);
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        mismatches++;
        finish_test;
    end

    initial begin
        do_reset(0, 0);
        chk("headroom", 200, system_headroom_mv);
        chk("bsw_mode", 0, battery_switch_mode);
        i_host.write_ctrl(1, 0, 0, 0);
        start_ok(0, 0);
        chk("target", 11'h5a5, ramp_voltage_target);
        chk("cur_limit", 7'h33, output_current_limit);
        for (int i = 0; i < 2; i++) begin
            reverse_pulse_freq_disable = i[0];
            reverse_audio_floor_disable = !i[0];
            cyc(3);
            chk("pfm_en", !i[0], pulse_frequency_mode_en);
            chk("floor_en", i[0], audio_frequency_floor_en);
        end
        discharge_level = 2'h3;
        cyc(6);
        chk("dis_status", 1, discharge_limit_status);
        chk("dis_reduce", 1, output_current_reduce);
        chk("dis_flag", 1, discharge_limit_flag);
        chk("irq_cnt", 1, irq_cnt);
        discharge_level = 2'h1;
        discharge_limit_flag_clear = 1;
        cyc(6);
        discharge_limit_flag_clear = 0;
        discharge_limit_mask = 1;
        chk("dis_status", 0, discharge_limit_status);
        discharge_level = 2'h2;
        cyc(6);
        chk("dis_status", 1, discharge_limit_status);
        chk("dis_flag", 0, discharge_limit_flag);
        chk("irq_cnt", 1, irq_cnt);
        discharge_level = 2'h0;
        i_host.write_ctrl(0, 0, 0, 0);
        cyc(2);
        chk("switching", 0, converter_switching);
        $display("test run and discharge done");
        for (int k = 0; k < 5; k++) begin
            thermistor_input = (k == 0) ? 8'hc1 : 8'hc0;
            battery_overvoltage = (k == 1);
            bus_below_uvlo = (k != 2);
            battery_above_otg_rise = (k != 3);
            cyc(4);
            i_host.write_ctrl(1, 0, 0, 0);
            if (k == 4) begin
                cyc(SC / 2);
                i_host.write_ctrl(0, 0, 0, 0);
            end
            stays_off("refused");
            i_host.write_ctrl(0, 0, 0, 0);
        end
        $display("test refusal done");
        do_reset(1, 0);
        i_host.write_ctrl(1, 0, 0, 0);
        stays_off("one_pair_wait");
        i_host.write_ctrl(1, 0, 1, 0);
        stays_off("wrong_driver");
        i_host.write_ctrl(1, 1, 0, 0);
        start_ok(1, 0);
        $display("test one pair done");
        do_reset(1, 1);
        i_host.write_ctrl(1, 0, 0, 0);
        stays_off("two_pair_wait");
        i_host.write_ctrl(1, 0, 1, 0);
        start_ok(0, 1);
        i_host.write_ctrl(1, 0, 0, 0);
        cyc(3);
        chk("swap_off", 0, converter_switching);
        i_host.write_ctrl(1, 1, 0, 0);
        start_ok(1, 0);
        i_host.write_ctrl(0, 0, 0, 1);
        cyc(4);
        i_host.write_ctrl(1, 1, 1, 1);
        start_ok(0, 0);
        $display("test pairs and swap done");
        for (int i = 0; i < 2; i++) begin
            system_at_min = i[0];
            input_voltage_limit_loop = i[0];
            input_current_limit_loop = !i[0];
            cyc(5);
            chk("min_sys", i[0], min_system_reg_status);
            chk("vin_reg", i[0], input_voltage_reg_status);
            chk("iin_reg", !i[0], input_current_reg_status);
        end
        battery_below_min_system = 1;
        cyc(5);
        chk("bsw_mode", 1, battery_switch_mode);
        chk("headroom", 200, system_headroom_mv);
        battery_below_min_system = 0;
        system_below_battery = 1;
        cyc(5);
        chk("bsw_mode", 2, battery_switch_mode);
        battery_depleted = 1;
        cyc(5);
        chk("bsw_mode", 0, battery_switch_mode);
        system_below_battery = 0;
        battery_depleted = 0;
        charge_enable = 1;
        cyc(5);
        chk("bsw_mode", 2, battery_switch_mode);
        chk("headroom", 0, system_headroom_mv);
        reverse_pulse_freq_disable = 0;
        charge_terminated = 1;
        cyc(5);
        chk("bsw_mode", 0, battery_switch_mode);
        chk("headroom", 600, system_headroom_mv);
        $display("test status done");
        finish_test;
    end
endmodule
